// >>> design/wdr_pkg.sv
/*
 * Shared constants for the windowed watchdog: register offsets, field
 * positions, reset values, key, prescaler ratio and small helpers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package wdr_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 12;

   localparam logic [7:0] OFS_RESTART = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

   localparam logic [7:0] RESTART_KEY = 8'hA5;
   localparam int KEY_LSB = 24;
   localparam int RESTART_BIT = 0;

   localparam int RELOAD_LSB = 0;
   localparam int FIE_BIT = 12;
   localparam int RSTEN_BIT = 13;
   localparam int PROC_BIT = 14;
   localparam int DIS_BIT = 15;
   localparam int DELTA_LSB = 16;
   localparam int DBG_BIT = 28;
   localparam int IDLE_BIT = 29;

   localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
   localparam logic [31:0] MODE_MASK = 32'h3FFF_FFFF;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
   localparam int UNF_BIT = 0;
   localparam int ERR_BIT = 1;

   localparam int PRESC_DIV = 128;
   localparam logic [6:0] PRESC_LAST = 7'(PRESC_DIV - 1);

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sticky flag: a set in the clearing cycle survives
   function automatic logic flag_next(input logic old, input logic set, input logic clr);
      flag_next = set | (old & ~clr);
   endfunction : flag_next

   function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
      hits = addr[7:2] == ofs[7:2];
   endfunction : hits

endpackage : wdr_pkg

// >>> design/wdr_presc_if.sv
/*
 * Link between the watchdog core and its divide-by-128 prescaler.
 * Assumes both ends share aclk; clear and run are combinational from the core.
 */
`timescale 1ns/100ps
`default_nettype none

interface wdr_presc_if;
   logic clear;
   logic run;
   logic tick;

   modport ctl (output clear, output run, input tick);
   modport div (input clear, input run, output tick);
endinterface : wdr_presc_if

`default_nettype wire

// >>> design/wdr_presc.sv
/*
 * Divide-by-128 prescaler on the slow clock ticks; one-cycle tick out.
 * Assumes run is a one-cycle slow clock pulse already gated by enable and halt.
 */
`timescale 1ns/100ps
`default_nettype none

module wdr_presc (
   input wire logic aclk,
   input wire logic aresetn,
   wdr_presc_if.div pif
);

   typedef struct packed {
      logic [6:0] cnt;
      logic tick;
   } wdr_presc_t;

   wdr_presc_t q;
   wdr_presc_t n;

   always_comb
   begin
      n = q;
      n.tick = 1'b0;
      if (pif.clear)
      begin
         n.cnt = 7'h00; // see [R15]
      end
      else if (pif.run)
      begin
         if (q.cnt == wdr_pkg::PRESC_LAST)
         begin
            n.cnt = 7'h00;
            n.tick = 1'b1; // see [R15]
         end
         else
         begin
            n.cnt = q.cnt + 7'h01;
         end
      end
      if (!aresetn)
      begin
         n = '0;
      end
   end

   always_ff @(posedge aclk)
   begin
      q <= n;
   end

   assign pif.tick = q.tick;

   tick_period_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R15]
      q.tick |-> ($past(q.cnt) == wdr_pkg::PRESC_LAST) && $past(pif.run) && !$past(pif.clear))
      else $error("prescaler tick without 128 slow ticks");

endmodule : wdr_presc

`default_nettype wire

// >>> design/wdr_top.sv
/*
 * Windowed watchdog with key-protected restart, write-once mode register,
 * read-clear fault status and a maskable interrupt, on AXI4-Lite.
 * Assumes slow_tick is a one-cycle pulse per slow clock period, synchronous
 * to aclk, and that the reset controller acts on the fault outputs.
 */
// Contract
// [R1] Control write needs key 0xA5 in top byte
// [R2] Accepted restart bit restarts the counter
// [R3] Reload field feeds the 12-bit counter
// [R4] Interrupt enable lets faults raise interrupt
// [R5] Reset enable lets faults request reset
// [R6] Scope bit picks all or processor reset
// [R7] Restart reloads only when count within delta
// [R8] Restart above delta is a window error
// [R9] Debug halt bit stops counting in debug
// [R10] Idle halt bit stops counting in idle
// [R11] Disable bit stops the watchdog; code stops only the counter, the restart window check still raises errors
// [R12] Underflow flag sticks until status read
// [R13] Error flag sticks until status read
// [R14] Mode register written once, write reloads
// [R15] Counter steps on slow clock divided 128
// [R16] Status read clears flags, interrupt, fault
// [R17] Mode field layout as fixed bit positions
`timescale 1ns/100ps
`default_nettype none

module wdr_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic slow_tick,
   input wire logic debug_halted,
   input wire logic idle_mode,
   output logic wdt_irq,
   output logic fault_all_reset,
   output logic fault_proc_reset
);

   typedef struct packed {
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] mode;
      logic mode_locked;
      logic [11:0] count;
      logic unf_flag;
      logic err_flag;
      logic fault_all;
      logic fault_proc;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic irq;
   } wdr_state_t;

   wdr_state_t q;
   wdr_state_t n;

   wdr_presc_if pif ();

   wdr_presc u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .pif(pif)
   );

   logic [11:0] reload_val;
   logic [11:0] delta_val;
   logic fie;
   logic rsten;
   logic proc_only;
   logic dis;
   logic halt_now;
   logic full_strb;
   logic wr_exec;
   logic wr_mapped;
   logic restart_cmd;
   logic err_ev;
   logic good_restart;
   logic mode_wr;
   logic unf_ev;
   logic fault_ev;
   logic rd_take;
   logic status_rd;
   logic rd_mapped;
   logic [1:0] irq_clr;

   assign reload_val = q.mode[wdr_pkg::RELOAD_LSB +: wdr_pkg::CNT_W]; // see [R17]
   assign delta_val = q.mode[wdr_pkg::DELTA_LSB +: wdr_pkg::CNT_W]; // see [R17]
   assign fie = q.mode[wdr_pkg::FIE_BIT];
   assign rsten = q.mode[wdr_pkg::RSTEN_BIT];
   assign proc_only = q.mode[wdr_pkg::PROC_BIT];
   assign dis = q.mode[wdr_pkg::DIS_BIT];

   // Halt bits gate the slow tick; a tick already in flight still lands
   assign halt_now = (q.mode[wdr_pkg::DBG_BIT] && debug_halted) // see [R9]
      || (q.mode[wdr_pkg::IDLE_BIT] && idle_mode); // see [R10]

   // Partial-word writes are ignored so the key can never be forged by lanes
   assign full_strb = q.wstrb == 4'hF;
   assign wr_exec = q.aw_held && q.w_held && !q.bvalid;
   assign wr_mapped = wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_RESTART)
      || wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_MODE)
      || wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_STATUS)
      || wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_IRQ_STATUS)
      || wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_IRQ_MASK);

   assign restart_cmd = wr_exec && full_strb && wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_RESTART)
      && (q.wdata[wdr_pkg::KEY_LSB +: 8] == wdr_pkg::RESTART_KEY) // see [R1]
      && q.wdata[wdr_pkg::RESTART_BIT]; // see [R2]
   // Window check applies even while disabled
   assign err_ev = restart_cmd && (q.count > delta_val); // see [R8]
   assign good_restart = restart_cmd && !err_ev; // see [R7]
   assign mode_wr = wr_exec && full_strb && !q.mode_locked
      && wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_MODE); // see [R14]

   assign pif.clear = good_restart || mode_wr; // see [R15]
   assign pif.run = slow_tick && !dis && !halt_now; // see [R11]
   assign unf_ev = pif.tick && (q.count == 12'h000);
   assign fault_ev = unf_ev || err_ev;

   assign rd_take = s_axi_arvalid && q.arready;
   assign status_rd = rd_take && wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_STATUS); // see [R16]
   assign rd_mapped = wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_RESTART)
      || wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_MODE)
      || wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_STATUS)
      || wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_IRQ_STATUS)
      || wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_IRQ_MASK);

   always_comb
   begin
      irq_clr = 2'h0;
      if (status_rd)
      begin
         irq_clr = 2'h3; // see [R16]
      end
      else if (wr_exec && full_strb && wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_IRQ_STATUS))
      begin
         irq_clr = q.wdata[1:0];
      end
   end

   always_comb
   begin
      n = q;

      // Write channels, taken in either order, answered once both are held
      if (q.bvalid && s_axi_bready)
      begin
         n.bvalid = 1'b0;
      end
      if (s_axi_awvalid && q.awready)
      begin
         n.aw_held = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready)
      begin
         n.w_held = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (wr_exec)
      begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = wr_mapped ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
         if (full_strb && wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_IRQ_MASK))
         begin
            n.irq_mask = q.wdata[1:0];
         end
      end
      n.awready = !n.aw_held;
      n.wready = !n.w_held;

      // Read channel
      if (q.rvalid && s_axi_rready)
      begin
         n.rvalid = 1'b0;
      end
      if (rd_take)
      begin
         n.rvalid = 1'b1;
         n.rresp = rd_mapped ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
         n.rdata = 32'h0000_0000;
         if (wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_MODE))
         begin
            n.rdata = q.mode;
         end
         else if (wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_STATUS))
         begin
            n.rdata = {30'h0000_0000, q.err_flag, q.unf_flag};
         end
         else if (wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_IRQ_STATUS))
         begin
            n.rdata = {30'h0000_0000, q.irq_status};
         end
         else if (wdr_pkg::hits(s_axi_araddr, wdr_pkg::OFS_IRQ_MASK))
         begin
            n.rdata = {30'h0000_0000, q.irq_mask};
         end
      end
      n.arready = !n.rvalid;

      // Mode register, once only
      if (mode_wr)
      begin
         n.mode = q.wdata & wdr_pkg::MODE_MASK;
         n.mode_locked = 1'b1; // see [R14]
      end

      // Down counter; underflow reloads so the period keeps repeating
      if (mode_wr)
      begin
         n.count = q.wdata[wdr_pkg::RELOAD_LSB +: wdr_pkg::CNT_W]; // see [R14]
      end
      else if (good_restart)
      begin
         n.count = reload_val; // see [R3]
      end
      else if (pif.tick)
      begin
         n.count = unf_ev ? reload_val : q.count - 12'h001; // see [R15]
      end

      n.unf_flag = wdr_pkg::flag_next(q.unf_flag, unf_ev, status_rd); // see [R12]
      n.err_flag = wdr_pkg::flag_next(q.err_flag, err_ev, status_rd); // see [R13]
      n.fault_all = wdr_pkg::flag_next(q.fault_all, fault_ev && rsten && !proc_only, status_rd); // see [R6]
      n.fault_proc = wdr_pkg::flag_next(q.fault_proc, fault_ev && rsten && proc_only, status_rd); // see [R5]
      n.irq_status[wdr_pkg::UNF_BIT] = wdr_pkg::flag_next(q.irq_status[wdr_pkg::UNF_BIT],
         unf_ev && fie, irq_clr[wdr_pkg::UNF_BIT]); // see [R4]
      n.irq_status[wdr_pkg::ERR_BIT] = wdr_pkg::flag_next(q.irq_status[wdr_pkg::ERR_BIT],
         err_ev && fie, irq_clr[wdr_pkg::ERR_BIT]); // see [R4]
      n.irq = |(n.irq_status & n.irq_mask);

      if (!aresetn)
      begin
         n = '0;
         n.mode = wdr_pkg::MODE_RESET;
         n.count = wdr_pkg::MODE_RESET[wdr_pkg::RELOAD_LSB +: wdr_pkg::CNT_W];
         n.irq_mask = wdr_pkg::IRQ_MASK_RESET;
      end
   end

   always_ff @(posedge aclk)
   begin
      q <= n;
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign wdt_irq = q.irq;
   assign fault_all_reset = q.fault_all;
   assign fault_proc_reset = q.fault_proc;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   bad_key_a: assert property ( // see [R1]
      (wr_exec && wdr_pkg::hits(q.awaddr, wdr_pkg::OFS_RESTART)
         && q.wdata[31:24] != wdr_pkg::RESTART_KEY) |=> !$rose(q.err_flag) && !$past(pif.clear))
      else $error("restart write with bad key had an effect");

   restart_reload_a: assert property ( // see [R2]
      good_restart |=> (q.count == reload_val) && !q.err_flag || $past(q.err_flag))
      else $error("accepted restart did not reload the counter");

   window_err_a: assert property ( // see [R8]
      (restart_cmd && q.count > delta_val) |=> q.err_flag
         && (q.count == $past(q.count) - 12'($past(pif.tick))))
      else $error("restart outside window not flagged as error");

   irq_gate_a: assert property ( // see [R4]
      (!fie && q.irq_status == 2'h0) |=> q.irq_status == 2'h0)
      else $error("interrupt status set with interrupt enable clear");

   reset_gate_a: assert property ( // see [R5]
      (!rsten && !q.fault_all && !q.fault_proc) |=> !q.fault_all && !q.fault_proc)
      else $error("fault output raised with reset enable clear");

   reset_scope_a: assert property ( // see [R6]
      $rose(q.fault_proc) |-> $past(proc_only) && !$rose(q.fault_all))
      else $error("processor-only fault without scope bit");

   halt_stop_a: assert property ( // see [R9]
      (halt_now && !pif.clear) ##1 (halt_now && !pif.clear) |=> $stable(q.count))
      else $error("counter moved while halted");

   disable_stop_a: assert property ( // see [R11]
      (dis && !pif.clear) ##1 (dis && !pif.clear) |=> $stable(q.count))
      else $error("counter moved while disabled");

   unf_flag_a: assert property ( // see [R12]
      unf_ev |=> q.unf_flag && (q.count == reload_val))
      else $error("underflow not flagged");

   read_clear_a: assert property ( // see [R16]
      (status_rd && !fault_ev) |=> !q.unf_flag && !q.err_flag && !q.fault_all && !q.fault_proc
         && q.irq_status == 2'h0)
      else $error("status read did not clear flags");

   mode_once_a: assert property ( // see [R14]
      q.mode_locked |=> $stable(q.mode))
      else $error("mode register changed after first write");

endmodule : wdr_top

`default_nettype wire

// >>> verif/wdr_rstc_model.sv
/*
 * Reset controller stand-in: counts fault requests of each scope.
 * Assumes the fault levels are registered on aclk.
 */
`timescale 1ns/100ps
`default_nettype none

module wdr_rstc_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fault_all_reset,
   input wire logic fault_proc_reset,
   output logic [7:0] all_cnt_q,
   output logic [7:0] proc_cnt_q
);
   logic all_q;
   logic proc_q;

   // Rising edges only: a level held high is one request
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         all_q <= 1'b0;
         proc_q <= 1'b0;
         all_cnt_q <= 8'h00;
         proc_cnt_q <= 8'h00;
      end
      else
      begin
         all_q <= fault_all_reset;
         proc_q <= fault_proc_reset;
         all_cnt_q <= all_cnt_q + 8'((fault_all_reset & ~all_q));
         proc_cnt_q <= proc_cnt_q + 8'((fault_proc_reset & ~proc_q));
      end
   end
endmodule : wdr_rstc_model

`default_nettype wire

// >>> verif/tb_top.sv
/*
 * Self-checking bench for the windowed watchdog.
 * Assumes slow_tick high every cycle and the reset controller model.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} wdr_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic slow_tick = 1'b1;
   logic debug_halted = 1'b0;
   logic idle_mode = 1'b0;
   logic wdt_irq;
   logic f_all;
   logic f_proc;
   logic [7:0] all_cnt;
   logic [7:0] proc_cnt;
   logic [31:0] rdat;
   logic [1:0] rsp;
   logic [1:0] wrsp;
   int errors = 0;
   int checks = 0;
   wdr_row_t rows [5] = '{'{wdr_pkg::OFS_MODE, 32'h3FFF_2FFF, wdr_pkg::RESP_OKAY},
      '{wdr_pkg::OFS_STATUS, 32'h0, wdr_pkg::RESP_OKAY}, '{wdr_pkg::OFS_RESTART, 32'h0, wdr_pkg::RESP_OKAY},
      '{wdr_pkg::OFS_IRQ_MASK, 32'h3, wdr_pkg::RESP_OKAY}, '{8'h14, 32'h0, wdr_pkg::RESP_SLVERR}};
   logic [31:0] hmodes [3] = '{32'h0000_9001, 32'h1000_1001, 32'h2000_1001};

   wdr_top i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .slow_tick(slow_tick), .debug_halted(debug_halted), .idle_mode(idle_mode),
      .wdt_irq(wdt_irq), .fault_all_reset(f_all), .fault_proc_reset(f_proc)
   );

   wdr_rstc_model i_rstc (
      .aclk(aclk), .aresetn(aresetn), .fault_all_reset(f_all), .fault_proc_reset(f_proc),
      .all_cnt_q(all_cnt), .proc_cnt_q(proc_cnt)
   );

   initial
   begin
      forever #4 aclk = ~aclk;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Handshakes judged at the negedge, so the edge sample is race free
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ha;
      logic hw;
      logic hb;
      hb = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle limit here: only the watchdog ends a hung wait
      while (!hb)
      begin
         @(negedge aclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid & bready;
         wrsp = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic ha;
      logic hr;
      hr = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hr)
      begin
         @(negedge aclk);
         ha = arvalid & arready;
         hr = rvalid & rready;
         rdat = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rdat, exp);
   endtask : rdchk

   task automatic settle();
      repeat (2) @(posedge aclk);
      @(negedge aclk);
   endtask : settle

   task automatic reset_dut();
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(32'({wdt_irq, f_all, f_proc}), 32'h0);
   endtask : reset_dut

   initial
   begin
      #320000;
      errors++;
      complete_run();
   end

   initial
   begin
      reset_dut();
      foreach (rows[i])
      begin
         rd(rows[i].a);
         chk(rdat, rows[i].d);
         chk(32'(rsp), 32'(rows[i].r));
      end
      wr(8'h14, 32'hA500_0001, 4'hF);
      chk(32'(wrsp), 32'(wdr_pkg::RESP_SLVERR));
      $display("test 0 done");
      wr(wdr_pkg::OFS_MODE, 32'h0002_3005, 4'hF);
      wr(wdr_pkg::OFS_RESTART, 32'h5A00_0001, 4'hF);
      chk(32'(wrsp), 32'(wdr_pkg::RESP_OKAY));
      wr(wdr_pkg::OFS_RESTART, 32'hA500_0000, 4'hF);
      wr(wdr_pkg::OFS_RESTART, 32'hA500_0001, 4'h7);
      rdchk(wdr_pkg::OFS_STATUS, 32'h0);
      wr(wdr_pkg::OFS_RESTART, 32'hA500_0001, 4'hF);
      wr(wdr_pkg::OFS_MODE, 32'h0000_0FFF, 4'hF);
      rdchk(wdr_pkg::OFS_MODE, 32'h0002_3005);
      chk(32'({wdt_irq, f_all, f_proc}), 32'h6);
      rdchk(wdr_pkg::OFS_STATUS, 32'h2);
      settle();
      chk(32'({wdt_irq, f_all, f_proc}), 32'h0);
      rdchk(wdr_pkg::OFS_STATUS, 32'h0);
      chk(32'(all_cnt), 32'h1);
      $display("test 1 done");
      // Window opens once the count has fallen to the delta of 2
      reset_dut();
      wr(wdr_pkg::OFS_MODE, 32'h0002_3005, 4'hF);
      repeat (450) @(posedge aclk);
      wr(wdr_pkg::OFS_RESTART, 32'hA500_0001, 4'hF);
      rdchk(wdr_pkg::OFS_STATUS, 32'h0);
      repeat (700) @(posedge aclk);
      @(negedge aclk);
      chk(32'(wdt_irq), 32'h0);
      repeat (120) @(negedge aclk);
      chk(32'({wdt_irq, f_all}), 32'h3);
      wr(wdr_pkg::OFS_IRQ_MASK, 32'h0, 4'hF);
      settle();
      chk(32'(wdt_irq), 32'h0);
      wr(wdr_pkg::OFS_IRQ_MASK, 32'h3, 4'hF);
      settle();
      chk(32'(wdt_irq), 32'h1);
      wr(wdr_pkg::OFS_IRQ_STATUS, 32'h1, 4'hF);
      settle();
      chk(32'(wdt_irq), 32'h0);
      rdchk(wdr_pkg::OFS_STATUS, 32'h1);
      $display("test 2 done");
      reset_dut();
      wr(wdr_pkg::OFS_MODE, 32'h0000_6001, 4'hF);
      wr(wdr_pkg::OFS_RESTART, 32'hA500_0001, 4'hF);
      settle();
      chk(32'({wdt_irq, f_all, f_proc}), 32'h1);
      chk(32'(proc_cnt), 32'h1);
      reset_dut();
      rdchk(wdr_pkg::OFS_STATUS, 32'h0);
      $display("test 3 done");
      // Disabled, then debug halt, then idle halt
      for (int i = 0; i < 3; i++)
      begin
         reset_dut();
         debug_halted <= (i == 1);
         idle_mode <= (i == 2);
         wr(wdr_pkg::OFS_MODE, hmodes[i], 4'hF);
         repeat (600) @(posedge aclk);
         rdchk(wdr_pkg::OFS_STATUS, 32'h0);
         debug_halted <= 1'b0;
         idle_mode <= 1'b0;
         repeat (300) @(posedge aclk);
         rdchk(wdr_pkg::OFS_STATUS, 32'(i != 0));
      end
      $display("test 4 done");
      complete_run();
   end
endmodule : tb_top

`default_nettype wire
